/* dv/tb_top.sv */
// Self-checking bench for the clock and power mode controller
`timescale 1ns/100ps
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [3:0] tk = 4'h0;
	logic pll_lock_i = 1'b0;
	logic pll_pd_o, pll_bypass_o, main_ce_o, core_ce_o, wdt_clk_ce_o, clock_output_pin_o;
	logic [5:0] pll_mult_o;
	logic [4:0] pll_post_div_o;
	logic [15:0] periph_ce_o;
	clk_pwr_pkg::wake_src_t wk = '0;
	logic irq_i = 1'b0;
	logic dpd_resume_pin_n_i = 1'b1;
	clk_pwr_pkg::osc_ctrl_t osc_o;
	clk_pwr_pkg::pwr_state_t pwr_state_o;
	int err_count = 0;
	int comparisons = 0;
	logic [31:0] rd;
	logic p0;
	int n;

	// Short settle count keeps the run brief
	clock_power_mode_control #(.NP(16), .PLL_SETTLE_CYC(20)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irc_tick_i(tk[0]), .sysosc_tick_i(tk[1]),
		.wdosc_tick_i(tk[2]), .pll_tick_i(tk[3]), .pll_lock_i(pll_lock_i),
		.pll_pd_o(pll_pd_o), .pll_bypass_o(pll_bypass_o), .pll_mult_o(pll_mult_o),
		.pll_post_div_o(pll_post_div_o), .main_ce_o(main_ce_o), .core_ce_o(core_ce_o),
		.periph_ce_o(periph_ce_o), .wdt_clk_ce_o(wdt_clk_ce_o),
		.clock_output_pin_o(clock_output_pin_o), .wake_i(wk), .irq_i(irq_i),
		.dpd_resume_pin_n_i(dpd_resume_pin_n_i), .osc_o(osc_o), .pwr_state_o(pwr_state_o));

	initial begin
		forever #2 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic report_and_stop;
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	// Request held until ack is sampled at a rising edge
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= dat;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		#1;
	endtask : wb_xfer

	task automatic wait_state(input clk_pwr_pkg::pwr_state_t s);
		n = 0;
		while (pwr_state_o !== s && n < 20) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk(pwr_state_o, s);
	endtask : wait_state

	task automatic count_core(input int cyc);
		n = 0;
		repeat (cyc) begin
			@(posedge clk_i);
			#1;
			if (core_ce_o === 1'b1) n++;
		end
	endtask : count_core

	initial begin
		#80000;
		err_count++;
		report_and_stop();
	end

	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk({pll_pd_o, pll_bypass_o}, 2'b11);
		chk(pll_mult_o, 6'd1);
		chk(pll_post_div_o, 5'd2);
		chk(pwr_state_o, clk_pwr_pkg::PWR_ACTIVE);
		wb_xfer(1'b0, clk_pwr_pkg::OFS_STATUS, 0);
		chk(rd[1:0], 2'h0);
		// Output pin follows only the chosen source; main runs from RC here
		for (int s = 0; s < 4; s++) begin
			wb_xfer(1'b1, clk_pwr_pkg::OFS_CLOCK_OUTPUT_PIN, 32'h4 | s);
			for (int k = 0; k < 3; k++) begin
				p0 = clock_output_pin_o;
				@(posedge clk_i) tk <= 4'h1 << k;
				@(posedge clk_i) tk <= 4'h0;
				@(posedge clk_i);
				#1;
				chk(clock_output_pin_o, p0 ^ (k == s || (s == 3 && k == 0)));
			end
		end
		@(posedge clk_i) tk <= 4'h1;
		wb_xfer(1'b1, clk_pwr_pkg::OFS_GATE, 32'h0005);
		@(posedge clk_i);
		#1;
		chk(periph_ce_o, 16'h0005);
		chk({main_ce_o, wdt_clk_ce_o}, 2'b10);
		wb_xfer(1'b1, clk_pwr_pkg::OFS_CORE_DIV, 32'h2);
		count_core(12);
		chk(n, 4);
		wb_xfer(1'b1, clk_pwr_pkg::OFS_PWR_CFG, 32'h10);
		wait_state(clk_pwr_pkg::PWR_SLEEP);
		count_core(6);
		chk(n, 0);
		chk(periph_ce_o, 16'h0005);
		@(posedge clk_i) irq_i <= 1'b1;
		wait_state(clk_pwr_pkg::PWR_ACTIVE);
		@(posedge clk_i) irq_i <= 1'b0;
		wb_xfer(1'b1, clk_pwr_pkg::OFS_WAKE_EN, 32'h101);
		wb_xfer(1'b1, clk_pwr_pkg::OFS_PWR_CFG, 32'h33);
		wait_state(clk_pwr_pkg::PWR_DEEP);
		count_core(2);
		chk(n, 0);
		chk(periph_ce_o, 16'h0000);
		chk(osc_o[7:3], 5'b10011);
		@(posedge clk_i) wk.gpio[0] <= 1'b1;
		wait_state(clk_pwr_pkg::PWR_ACTIVE);
		@(posedge clk_i) wk.gpio[0] <= 1'b0;
		wb_xfer(1'b1, clk_pwr_pkg::OFS_PWR_CFG, 32'h50);
		wait_state(clk_pwr_pkg::PWR_PD);
		chk({osc_o[7], osc_o[5:4], osc_o[1]}, 4'b0001);
		// Serial port irq without low-power mode must not wake
		@(posedge clk_i) wk.usart_irq[0] <= 1'b1;
		repeat (10) @(posedge clk_i);
		#1;
		chk(pwr_state_o, clk_pwr_pkg::PWR_PD);
		@(posedge clk_i) wk.usart_lp[0] <= 1'b1;
		wait_state(clk_pwr_pkg::PWR_ACTIVE);
		@(posedge clk_i) wk.usart_irq[0] <= 1'b0;
		wk.usart_lp[0] <= 1'b0;
		for (int p = 0; p < 4; p++) begin
			wb_xfer(1'b1, clk_pwr_pkg::OFS_PLL_CTRL, (p << 5) | (p == 0 ? 0 : 31));
			chk(pll_mult_o, p == 0 ? 6'd1 : 6'd32);
			chk(pll_post_div_o, 5'd2 << p);
		end
		chk(pll_pd_o, 1'b1);
		wb_xfer(1'b1, clk_pwr_pkg::OFS_PLL_CTRL, 32'h80);
		chk(pll_pd_o, 1'b0);
		@(posedge clk_i) pll_lock_i <= 1'b1;
		repeat (30) @(posedge clk_i);
		wb_xfer(1'b0, clk_pwr_pkg::OFS_STATUS, 0);
		chk(rd[3], 1'b1);
		chk(rd[4], 1'b1);
		@(posedge clk_i) tk <= 4'hF;
		wb_xfer(1'b1, clk_pwr_pkg::OFS_MAIN_SEL, 32'h2);
		repeat (10) @(posedge clk_i);
		wb_xfer(1'b0, clk_pwr_pkg::OFS_STATUS, 0);
		chk(rd[2:0], 3'h2);
		// Lock set: deep power-down request refused
		wb_xfer(1'b1, clk_pwr_pkg::OFS_PWR_CFG, 32'h74);
		repeat (4) @(posedge clk_i);
		#1;
		chk(pwr_state_o, clk_pwr_pkg::PWR_ACTIVE);
		wb_xfer(1'b0, clk_pwr_pkg::OFS_STATUS, 0);
		chk(rd[8], 1'b1);
		wb_xfer(1'b1, clk_pwr_pkg::OFS_PWR_CFG, 32'h70);
		wait_state(clk_pwr_pkg::PWR_DPD);
		@(posedge clk_i) irq_i <= 1'b1;
		wk.gpio[0] <= 1'b1;
		repeat (8) @(posedge clk_i);
		#1;
		chk(pwr_state_o, clk_pwr_pkg::PWR_DPD);
		@(posedge clk_i) irq_i <= 1'b0;
		wk.gpio[0] <= 1'b0;
		dpd_resume_pin_n_i <= 1'b0;
		wait_state(clk_pwr_pkg::PWR_ACTIVE);
		@(posedge clk_i) dpd_resume_pin_n_i <= 1'b1;
		chk(pll_pd_o, 1'b1);
		wb_xfer(1'b0, clk_pwr_pkg::OFS_STATUS, 0);
		chk({rd[9], rd[1:0]}, 3'b100);
		wb_xfer(1'b0, clk_pwr_pkg::OFS_MAIN_SEL, 0);
		chk(rd[1:0], 2'h0);
		report_and_stop();
	end
endmodule : tb_top

/* pkg/clk_pwr_pkg.sv */
// Constants and types for the clock and power mode controller
package clk_pwr_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_MAIN_SEL = 8'h00;
	localparam logic [7:0] OFS_PLL_CTRL = 8'h04;
	localparam logic [7:0] OFS_CLOCK_OUTPUT_PIN = 8'h08;
	localparam logic [7:0] OFS_CORE_DIV = 8'h0C;
	localparam logic [7:0] OFS_GATE = 8'h10;
	localparam logic [7:0] OFS_PWR_CFG = 8'h14;
	localparam logic [7:0] OFS_WAKE_EN = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	// Field positions
	localparam int PLL_MSEL_LSB = 0;
	localparam int PLL_PSEL_LSB = 5;
	localparam int PLL_EN_BIT = 7;
	localparam int CO_EN_BIT = 2;
	localparam int CFG_KEEP_WDOSC = 0;
	localparam int CFG_KEEP_BOD = 1;
	localparam int CFG_DPD_LOCK = 2;
	localparam int CFG_WDT_IRC = 3;
	localparam int CFG_ENTER = 4;
	localparam int CFG_MODE_LSB = 5;
	localparam int WAKE_USART_LSB = 8;
	localparam int ST_BUSY = 2;
	localparam int ST_LOCK = 3;
	localparam int ST_SETTLED = 4;
	localparam int ST_PWR_LSB = 5;
	localparam int ST_REFUSED = 8;
	localparam int ST_WOKE = 9;
	// Reset values
	localparam logic [1:0] MAIN_SEL_RST = 2'h0;
	localparam logic [7:0] PLL_CTRL_RST = 8'h00;
	localparam logic [2:0] CLOCK_OUTPUT_PIN_RST = 3'h0;
	localparam logic [7:0] CORE_DIV_RST = 8'h00;
	localparam logic [31:0] GATE_RST = 32'hFFFFFFFF;
	localparam logic [7:0] PWR_CFG_RST = 8'h00;
	localparam logic [11:0] WAKE_EN_RST = 12'h000;
	// Timing
	localparam int IRC_MHZ = 12;
	localparam int CLK_MHZ = 250;
	localparam int PLL_SETTLE_US = 100;
	localparam int PLL_SETTLE_CYC = PLL_SETTLE_US * CLK_MHZ;
	typedef enum logic [1:0] {SRC_IRC = 2'h0, SRC_SYSOSC = 2'h1, SRC_PLL = 2'h2,
		SRC_WDOSC = 2'h3} main_src_t;
	typedef enum logic [1:0] {CO_IRC = 2'h0, CO_SYSOSC = 2'h1, CO_WDOSC = 2'h2,
		CO_MAIN = 2'h3} co_src_t;
	typedef enum logic [1:0] {REQ_SLEEP = 2'h0, REQ_DEEP = 2'h1, REQ_PD = 2'h2,
		REQ_DPD = 2'h3} pwr_req_t;
	typedef enum logic [2:0] {PWR_ACTIVE = 3'h0, PWR_SLEEP = 3'h1, PWR_DEEP = 3'h3,
		PWR_PD = 3'h2, PWR_DPD = 3'h6} pwr_state_t;
	typedef enum logic [1:0] {SW_RUN = 2'h0, SW_DRAIN = 2'h1, SW_ARM = 2'h3} sw_state_t;
	typedef struct packed {
		logic [7:0] gpio;
		logic [3:0] usart_irq;
		logic [3:0] usart_lp;
		logic wdt;
		logic rtc;
	} wake_src_t;
	typedef struct packed {
		logic irc_en;
		logic irc_out_en;
		logic sysosc_en;
		logic wdosc_en;
		logic bod_en;
		logic flash_standby;
		logic flash_pd;
		logic analog_pd;
	} osc_ctrl_t;
endpackage : clk_pwr_pkg

/* verilog/clock_power_mode_control.sv */
// Clock source selection, gating and low-power mode controller
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
// Functional notes
// - Reset or deep power-down wake selects the internal RC oscillator as main clock.
// - PLL multiplier accepts every integer from 1 to 32.
// - PLL post divider offers only 2, 4, 8 and 16.
// - After reset the PLL is powered off and bypassed until enabled.
// - Clock output pin takes RC, system, watchdog oscillator or main clock.
// - One gate bit per peripheral; clearing it stops that clock entirely.
// - Programmable divider sits between main clock and core clock.
// - Sleep stops only the core clock; interrupt or reset resumes.
// - Deep-sleep stops all but RC; RC output only feeds watchdog if selected.
// - Deep-sleep can keep watchdog oscillator and brownout detector running.
// - Deep-sleep and power-down end on reset, pins, watchdog, RTC, serial ports.
// - Serial port wakes only in 32 kHz, synchronous or CTS mode.
// - Power-down stops all sources but selected watchdog oscillator; flash off.
// - Deep power-down exits only on the resume pin or RTC wake.
// - Lock bit set refuses entry to deep power-down.
module clock_power_mode_control #(
	parameter int NP = 16,
	parameter int unsigned PLL_SETTLE_CYC = clk_pwr_pkg::PLL_SETTLE_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Oscillator ticks and PLL
	input wire logic irc_tick_i,
	input wire logic sysosc_tick_i,
	input wire logic wdosc_tick_i,
	input wire logic pll_tick_i,
	input wire logic pll_lock_i,
	output logic pll_pd_o,
	output logic pll_bypass_o,
	output logic [5:0] pll_mult_o,
	output logic [4:0] pll_post_div_o,
	// Clock enables and output pin
	output logic main_ce_o,
	output logic core_ce_o,
	output logic [NP-1:0] periph_ce_o,
	output logic wdt_clk_ce_o,
	output logic clock_output_pin_o,
	// Power control
	input wire clk_pwr_pkg::wake_src_t wake_i,
	input wire logic irq_i,
	input wire logic dpd_resume_pin_n_i,
	output clk_pwr_pkg::osc_ctrl_t osc_o,
	output clk_pwr_pkg::pwr_state_t pwr_state_o
);
	localparam int SW = $clog2(PLL_SETTLE_CYC + 1);
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	clk_pwr_pkg::main_src_t sel_q, sel_d, act_q, act_d;
	clk_pwr_pkg::sw_state_t sw_q, sw_d;
	clk_pwr_pkg::pwr_state_t pwr_q, pwr_d;
	logic [7:0] pll_q, pll_d, div_q, div_d, dcnt_q, dcnt_d, cfg_q, cfg_d;
	logic [2:0] co_q, co_d;
	logic [NP-1:0] gate_q, gate_d;
	logic [11:0] wen_q, wen_d;
	logic refused_q, refused_d, woke_q, woke_d, co_pin_q, co_pin_d;
	logic [SW-1:0] stl_q, stl_d;
	logic [1:0] lock_s, pin_s;
	logic [7:0] gs1_q, gs2_q;
	logic req, wr, rd, enter, dpd_exit, wake_any, running, co_tick;
	logic irc_ce, sys_ce, wd_ce, pll_ce;
	logic [31:0] m, gate32;
	logic [3:0] src_ticks, co_ticks;

	// Pin and PLL lock synchronisers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_s <= 2'h0;
			pin_s <= 2'h3;
			gs1_q <= 8'h00;
			gs2_q <= 8'h00;
		end else begin
			lock_s <= {lock_s[0], pll_lock_i};
			pin_s <= {pin_s[0], dpd_resume_pin_n_i};
			gs1_q <= wake_i.gpio;
			gs2_q <= gs1_q;
		end
	end

	// Oscillator and memory power per mode
	always_comb begin
		running = pwr_q == clk_pwr_pkg::PWR_ACTIVE || pwr_q == clk_pwr_pkg::PWR_SLEEP;
		osc_o.irc_en = running || pwr_q == clk_pwr_pkg::PWR_DEEP;
		osc_o.irc_out_en = running || (pwr_q == clk_pwr_pkg::PWR_DEEP
			&& cfg_q[clk_pwr_pkg::CFG_WDT_IRC]);
		osc_o.sysosc_en = running;
		osc_o.wdosc_en = running || (!osc_o.irc_en && pwr_q != clk_pwr_pkg::PWR_DPD
			&& cfg_q[clk_pwr_pkg::CFG_KEEP_WDOSC]) || (pwr_q == clk_pwr_pkg::PWR_DEEP
			&& cfg_q[clk_pwr_pkg::CFG_KEEP_WDOSC]);
		osc_o.bod_en = running || ((pwr_q == clk_pwr_pkg::PWR_DEEP || pwr_q ==
			clk_pwr_pkg::PWR_PD) && cfg_q[clk_pwr_pkg::CFG_KEEP_BOD]);
		osc_o.flash_standby = pwr_q == clk_pwr_pkg::PWR_DEEP;
		osc_o.flash_pd = pwr_q == clk_pwr_pkg::PWR_PD || pwr_q == clk_pwr_pkg::PWR_DPD;
		osc_o.analog_pd = !running;
	end

	// Source ticks, only while the oscillator is allowed to run
	assign irc_ce = irc_tick_i && osc_o.irc_out_en;
	assign sys_ce = sysosc_tick_i && osc_o.sysosc_en;
	assign wd_ce = wdosc_tick_i && osc_o.wdosc_en;
	// Disabled PLL passes its input straight through
	assign pll_ce = pll_q[clk_pwr_pkg::PLL_EN_BIT] ? (pll_tick_i && running) : irc_ce;
	assign src_ticks = {wd_ce, pll_ce, sys_ce, irc_ce};
	assign main_ce_o = running && src_ticks[act_q] && sw_q != clk_pwr_pkg::SW_ARM;
	assign core_ce_o = main_ce_o && dcnt_q == div_q && pwr_q == clk_pwr_pkg::PWR_ACTIVE;
	assign periph_ce_o = {NP{main_ce_o}} & gate_q;
	assign wdt_clk_ce_o = cfg_q[clk_pwr_pkg::CFG_WDT_IRC] ? irc_ce : wd_ce;
	assign co_ticks = {main_ce_o, wd_ce, sys_ce, irc_ce};
	assign co_tick = co_q[clk_pwr_pkg::CO_EN_BIT] && co_ticks[co_q[1:0]];
	assign pll_pd_o = !pll_q[clk_pwr_pkg::PLL_EN_BIT];
	assign pll_bypass_o = !pll_q[clk_pwr_pkg::PLL_EN_BIT];
	assign pll_mult_o = {1'b0, pll_q[4:0]} + 6'h01;
	assign pll_post_div_o = 5'h02 << pll_q[6:5];
	assign clock_output_pin_o = co_pin_q;
	assign pwr_state_o = pwr_q;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr = req && wb_we_i;
	assign rd = req && !wb_we_i;
	assign m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign gate32 = (32'(gate_q) & ~m) | (wb_dat_i & m);
	assign wake_any = |(gs2_q & wen_q[7:0]) || wake_i.wdt || wake_i.rtc
		|| |(wake_i.usart_irq & wake_i.usart_lp & wen_q[11:8]);

	// Next state of registers, switch and power sequencer
	always_comb begin
		sel_d = sel_q;
		pll_d = pll_q;
		co_d = co_q;
		div_d = div_q;
		gate_d = gate_q;
		cfg_d = cfg_q;
		wen_d = wen_q;
		act_d = act_q;
		sw_d = sw_q;
		pwr_d = pwr_q;
		dcnt_d = dcnt_q;
		rdat_d = rdat_q;
		enter = 1'b0;
		dpd_exit = 1'b0;
		refused_d = refused_q;
		woke_d = woke_q;
		ack_d = wb_cyc_i && wb_stb_i && !ack_q;
		co_pin_d = co_pin_q ^ co_tick;
		if (wr) begin
			unique case (wb_adr_i)
				clk_pwr_pkg::OFS_MAIN_SEL:
					if (m[0]) sel_d = clk_pwr_pkg::main_src_t'(wb_dat_i[1:0]);
				clk_pwr_pkg::OFS_PLL_CTRL: pll_d = (pll_q & ~m[7:0]) | (wb_dat_i[7:0] & m[7:0]);
				clk_pwr_pkg::OFS_CLOCK_OUTPUT_PIN: if (m[0]) co_d = wb_dat_i[2:0];
				clk_pwr_pkg::OFS_CORE_DIV: div_d = (div_q & ~m[7:0]) | (wb_dat_i[7:0] & m[7:0]);
				clk_pwr_pkg::OFS_GATE: gate_d = gate32[NP-1:0];
				clk_pwr_pkg::OFS_PWR_CFG: begin
					if (m[0]) begin
						cfg_d = wb_dat_i[7:0] & 8'hEF;
						enter = wb_dat_i[clk_pwr_pkg::CFG_ENTER];
					end
				end
				clk_pwr_pkg::OFS_WAKE_EN: wen_d = (wen_q & ~m[11:0]) | (wb_dat_i[11:0] & m[11:0]);
				clk_pwr_pkg::OFS_STATUS: begin
					if (m[1] && wb_dat_i[clk_pwr_pkg::ST_REFUSED]) refused_d = 1'b0;
					if (m[1] && wb_dat_i[clk_pwr_pkg::ST_WOKE]) woke_d = 1'b0;
				end
				default: ;
			endcase
		end
		if (rd) begin
			unique case (wb_adr_i)
				clk_pwr_pkg::OFS_MAIN_SEL: rdat_d = 32'(sel_q);
				clk_pwr_pkg::OFS_PLL_CTRL: rdat_d = 32'(pll_q);
				clk_pwr_pkg::OFS_CLOCK_OUTPUT_PIN: rdat_d = 32'(co_q);
				clk_pwr_pkg::OFS_CORE_DIV: rdat_d = 32'(div_q);
				clk_pwr_pkg::OFS_GATE: rdat_d = 32'(gate_q);
				clk_pwr_pkg::OFS_PWR_CFG: rdat_d = 32'(cfg_q);
				clk_pwr_pkg::OFS_WAKE_EN: rdat_d = 32'(wen_q);
				clk_pwr_pkg::OFS_STATUS: rdat_d = 32'({woke_q, refused_q, pwr_q,
					stl_q == SW'(PLL_SETTLE_CYC), lock_s[1], sw_q != clk_pwr_pkg::SW_RUN, act_q});
				default: rdat_d = 32'h00000000;
			endcase
		end
		// Hand over only on tick boundaries of both sources
		unique case (sw_q)
			clk_pwr_pkg::SW_RUN: if (sel_q != act_q) sw_d = clk_pwr_pkg::SW_DRAIN;
			clk_pwr_pkg::SW_DRAIN: begin
				if (src_ticks[act_q]) begin
					act_d = sel_q;
					sw_d = clk_pwr_pkg::SW_ARM;
				end
			end
			clk_pwr_pkg::SW_ARM: if (src_ticks[act_q]) sw_d = clk_pwr_pkg::SW_RUN;
			default: sw_d = clk_pwr_pkg::SW_RUN;
		endcase
		if (main_ce_o) dcnt_d = (dcnt_q >= div_q) ? 8'h00 : dcnt_q + 8'h01;
		unique case (pwr_q)
			clk_pwr_pkg::PWR_ACTIVE: begin
				if (enter) begin
					unique case (clk_pwr_pkg::pwr_req_t'(cfg_d[6:5]))
						clk_pwr_pkg::REQ_SLEEP: pwr_d = clk_pwr_pkg::PWR_SLEEP;
						clk_pwr_pkg::REQ_DEEP: pwr_d = clk_pwr_pkg::PWR_DEEP;
						clk_pwr_pkg::REQ_PD: pwr_d = clk_pwr_pkg::PWR_PD;
						clk_pwr_pkg::REQ_DPD: begin
							if (cfg_d[clk_pwr_pkg::CFG_DPD_LOCK]) refused_d = 1'b1;
							else pwr_d = clk_pwr_pkg::PWR_DPD;
						end
					endcase
				end
			end
			clk_pwr_pkg::PWR_SLEEP: if (irq_i || wake_any) pwr_d = clk_pwr_pkg::PWR_ACTIVE;
			clk_pwr_pkg::PWR_DEEP, clk_pwr_pkg::PWR_PD:
				if (wake_any) pwr_d = clk_pwr_pkg::PWR_ACTIVE;
			clk_pwr_pkg::PWR_DPD: begin
				if (!pin_s[1] || wake_i.rtc) begin
					pwr_d = clk_pwr_pkg::PWR_ACTIVE;
					dpd_exit = 1'b1;
					woke_d = 1'b1;
				end
			end
			default: pwr_d = clk_pwr_pkg::PWR_ACTIVE;
		endcase
		// Settling counter runs while the PLL is enabled
		stl_d = stl_q;
		if (!pll_q[clk_pwr_pkg::PLL_EN_BIT]) stl_d = '0;
		else if (stl_q != SW'(PLL_SETTLE_CYC)) stl_d = stl_q + 1'b1;
		// Core lost power in deep power-down, so wake restarts from RC
		if (rst_i || dpd_exit) begin
			sel_d = clk_pwr_pkg::main_src_t'(clk_pwr_pkg::MAIN_SEL_RST);
			act_d = clk_pwr_pkg::main_src_t'(clk_pwr_pkg::MAIN_SEL_RST);
			sw_d = clk_pwr_pkg::SW_RUN;
			pll_d = clk_pwr_pkg::PLL_CTRL_RST;
			co_d = clk_pwr_pkg::CLOCK_OUTPUT_PIN_RST;
			div_d = clk_pwr_pkg::CORE_DIV_RST;
			gate_d = clk_pwr_pkg::GATE_RST[NP-1:0];
			cfg_d = clk_pwr_pkg::PWR_CFG_RST;
			wen_d = clk_pwr_pkg::WAKE_EN_RST;
			dcnt_d = 8'h00;
			stl_d = '0;
			co_pin_d = 1'b0;
			refused_d = 1'b0;
		end
		if (rst_i) begin
			pwr_d = clk_pwr_pkg::PWR_ACTIVE;
			woke_d = 1'b0;
			ack_d = 1'b0;
			rdat_d = 32'h00000000;
		end
	end

	always_ff @(posedge clk_i) begin
		sel_q <= sel_d;
		act_q <= act_d;
		sw_q <= sw_d;
		pwr_q <= pwr_d;
		pll_q <= pll_d;
		co_q <= co_d;
		div_q <= div_d;
		gate_q <= gate_d;
		cfg_q <= cfg_d;
		wen_q <= wen_d;
		dcnt_q <= dcnt_d;
		stl_q <= stl_d;
		refused_q <= refused_d;
		woke_q <= woke_d;
		co_pin_q <= co_pin_d;
		ack_q <= ack_d;
		rdat_q <= rdat_d;
	end

	AST_IRC_AFTER_RESET: assert property (@(posedge clk_i) $fell(rst_i) |->
		act_q == clk_pwr_pkg::SRC_IRC && sel_q == clk_pwr_pkg::SRC_IRC)
		else $error("main clock not on RC after reset");
	AST_PLL_MULT: assert property (@(posedge clk_i) disable iff (rst_i)
		pll_mult_o != 6'h00 && pll_mult_o <= 6'h20)
		else $error("PLL multiplier out of range");
	AST_POST_DIV: assert property (@(posedge clk_i) disable iff (rst_i)
		$onehot(pll_post_div_o) && !pll_post_div_o[0])
		else $error("illegal PLL post divider");
	AST_PLL_OFF: assert property (@(posedge clk_i) $fell(rst_i) |->
		pll_pd_o && pll_bypass_o)
		else $error("PLL not off after reset");
	AST_CLOCK_OUTPUT_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
		co_tick |=> clock_output_pin_o != $past(clock_output_pin_o))
		else $error("clock output did not toggle");
	AST_CORE_DIV: assert property (@(posedge clk_i) disable iff (rst_i)
		core_ce_o |-> main_ce_o && pwr_q == clk_pwr_pkg::PWR_ACTIVE ##1 dcnt_q == 8'h00)
		else $error("core tick off divider phase");
	AST_SLEEP: assert property (@(posedge clk_i) disable iff (rst_i)
		pwr_q == clk_pwr_pkg::PWR_SLEEP |-> !core_ce_o && periph_ce_o == (gate_q & {NP{main_ce_o}})
		&& osc_o.irc_en && osc_o.sysosc_en)
		else $error("sleep clock gating wrong");
	AST_DEEP: assert property (@(posedge clk_i) disable iff (rst_i)
		pwr_q == clk_pwr_pkg::PWR_DEEP |-> periph_ce_o == '0 && !osc_o.sysosc_en
		&& osc_o.irc_out_en == cfg_q[clk_pwr_pkg::CFG_WDT_IRC])
		else $error("deep-sleep gating wrong");
	AST_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
		(pwr_q == clk_pwr_pkg::PWR_PD || pwr_q == clk_pwr_pkg::PWR_DEEP) && wake_any
		|=> pwr_q == clk_pwr_pkg::PWR_ACTIVE)
		else $error("missed wake from low power");
	AST_PD: assert property (@(posedge clk_i) disable iff (rst_i)
		pwr_q == clk_pwr_pkg::PWR_PD |-> !osc_o.irc_en && osc_o.flash_pd
		&& osc_o.wdosc_en == cfg_q[clk_pwr_pkg::CFG_KEEP_WDOSC])
		else $error("power-down sources wrong");
	AST_DPD_EXIT: assert property (@(posedge clk_i) disable iff (rst_i)
		pwr_q == clk_pwr_pkg::PWR_DPD && pin_s[1] && !wake_i.rtc |=> pwr_q == clk_pwr_pkg::PWR_DPD)
		else $error("deep power-down left without cause");
	AST_DPD_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
		pwr_q == clk_pwr_pkg::PWR_ACTIVE && enter && cfg_d[clk_pwr_pkg::CFG_DPD_LOCK]
		&& clk_pwr_pkg::pwr_req_t'(cfg_d[6:5]) == clk_pwr_pkg::REQ_DPD
		|=> pwr_q != clk_pwr_pkg::PWR_DPD && refused_q)
		else $error("locked deep power-down entered");
	// Deep power-down wake resets the mux while no source runs
	AST_SWITCH: assert property (@(posedge clk_i) disable iff (rst_i)
		act_q != $past(act_q) && $past(pwr_q) != clk_pwr_pkg::PWR_DPD
		|-> $past(sw_q) == clk_pwr_pkg::SW_DRAIN && !main_ce_o)
		else $error("unsafe main clock switch");
endmodule : clock_power_mode_control
